// ===== src/xmc_top.sv
// external memory bus controller: registers, bus sequencer, pin takeover
// assumes a cpu-side request port held until acknowledged and one clock
// Summary of operation
// - enable bit hands pins to the bus
// - clear enable returns pins to port control
// - limit code zero: one upper sector
// - limit codes set upper sector start address
// - upper wait field governs upper sector
// - lower wait field governs lower sector
// - wait codes stretch strobe zero, one, two
// - code three adds one address hold-off
// - keeper holds last driven low byte
// - keeper works regardless of bus enable
// - reserved keeper bits read as zero
// - mask zero uses all high pins
// - mask releases high pins from top down
// - internal addresses give no strobes
// - device decides internal or external itself
// - internal access shows no read/write strobe
// - low address valid at latch fall
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module xmc_top
	import xmc_pkg::*;
#(
	parameter bit SMALL_VARIANT = 1'b0
) (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        cpu_req,
	input  wire logic        cpu_we,
	input  wire logic [15:0] cpu_addr,
	input  wire logic [7:0]  cpu_wdata,
	output logic             cpu_ack,
	output logic [7:0]       cpu_rdata,
	output logic             cpu_ext,
	input  wire logic [7:0]  ad_port_val,
	input  wire logic [7:0]  ad_port_dir,
	input  wire logic [7:0]  ha_port_val,
	input  wire logic [7:0]  ha_port_dir,
	input  wire logic [2:0]  ctl_port_val,
	input  wire logic [2:0]  ctl_port_dir,
	input  wire logic [7:0]  muxed_addr_data_in,
	output logic [7:0]       muxed_addr_data_out,
	output logic             muxed_addr_data_oe_n,
	output logic [7:0]       high_addr_bus_out,
	output logic [7:0]       high_addr_bus_oe_n,
	output logic             ale_out,
	output logic             ale_oe_n,
	output logic             rd_n_out,
	output logic             rd_oe_n,
	output logic             wr_n_out,
	output logic             wr_oe_n,
	output logic             keeper_en,
	output logic [7:0]       keeper_val
);
	// ==========================================================
	// configuration registers
	logic [7:0] ext_mem_sector_wait_ctrl_r;
	logic [7:0] ext_mem_keeper_mask_ctrl_r;
	logic       ext_mem_enable;
	logic       bus_keeper_enable;
	logic [2:0] high_addr_mask;

	assign ext_mem_enable    = ext_mem_sector_wait_ctrl_r[XMC_EN_BIT];
	assign bus_keeper_enable = ext_mem_keeper_mask_ctrl_r[XMC_KEEP_BIT];
	assign high_addr_mask    = ext_mem_keeper_mask_ctrl_r[XMC_MASK_LSB +: 3];

	// ==========================================================
	// register port: write path
	logic       aw_got_r;
	logic       w_got_r;
	logic [7:0] aw_addr_r;
	logic [7:0] w_data_r;
	logic       w_lane0_r;
	logic       wr_fire;
	logic       wr_hit_a;
	logic       wr_hit_b;

	assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
	assign wr_fire  = aw_got_r && w_got_r && !s_axi_bvalid;
	assign wr_hit_a = ({aw_addr_r[7:2], 2'b00} == XMC_OFF_SECT_WAIT);
	assign wr_hit_b = ({aw_addr_r[7:2], 2'b00} == XMC_OFF_KEEP_MASK);

	// address and data may arrive in either order
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 8'h00;
			w_lane0_r <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_got_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_r   <= 1'b1;
				w_data_r  <= s_axi_wdata[7:0];
				w_lane0_r <= s_axi_wstrb[0];
			end
			else if (wr_fire)
				w_got_r <= 1'b0;
		end
	end

	// write response; unmapped addresses answer with a decode error
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= XMC_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_hit_a || wr_hit_b) ? XMC_RESP_OKAY : XMC_RESP_DECERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// register update; only byte lane 0 carries the 8-bit fields
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ext_mem_sector_wait_ctrl_r <= XMC_RST_SECT_WAIT;
			ext_mem_keeper_mask_ctrl_r <= XMC_RST_KEEP_MASK;
		end
		else if (wr_fire && w_lane0_r)
		begin
			if (wr_hit_a)
				ext_mem_sector_wait_ctrl_r <= w_data_r;
			if (wr_hit_b)
				ext_mem_keeper_mask_ctrl_r <= w_data_r & XMC_KEEP_RD_MASK;
		end
	end

	// ==========================================================
	// register port: read path
	xmc_state_t state_r;
	xmc_state_t state_nxt;
	logic       acc_ext_r;
	logic [1:0] wait_r;
	logic       rd_sel_b_r;
	logic [7:0] ar_word;

	assign s_axi_arready = !s_axi_rvalid;
	assign ar_word = {s_axi_araddr[7:2], 2'b00};

	// status shows whether the sequencer is busy, the last external flag and the last wait code
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= XMC_RESP_OKAY;
			rd_sel_b_r   <= 1'b0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= XMC_RESP_OKAY;
			rd_sel_b_r   <= (ar_word == XMC_OFF_KEEP_MASK);
			if (ar_word == XMC_OFF_SECT_WAIT)
				s_axi_rdata <= {24'h00_0000, ext_mem_sector_wait_ctrl_r};
			else if (ar_word == XMC_OFF_KEEP_MASK)
				s_axi_rdata <= {24'h00_0000, ext_mem_keeper_mask_ctrl_r & XMC_KEEP_RD_MASK};
			else if (ar_word == XMC_OFF_STATUS)
				s_axi_rdata <= {28'h000_0000, (state_r != XMC_ST_IDLE), acc_ext_r, wait_r};
			else
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= XMC_RESP_DECERR;
			end
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==========================================================
	// sector decode of the requested address
	xmc_dec_if dec_bus ();

	assign dec_bus.addr             = cpu_addr;
	assign dec_bus.sector_limit_sel = ext_mem_sector_wait_ctrl_r[XMC_LIM_LSB +: 3];
	assign dec_bus.upper_wait       = ext_mem_sector_wait_ctrl_r[XMC_UPW_LSB +: 2];
	assign dec_bus.lower_wait       = ext_mem_sector_wait_ctrl_r[XMC_LOW_LSB +: 2];

	xmc_sector_dec u_dec (
		.d (dec_bus.dec)
	);

	logic [7:0] ad_sync;

	xmc_sync3 #(.W(8)) u_ad_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.din      (muxed_addr_data_in),
		.dout     (ad_sync)
	);

	// ==========================================================
	// bus sequencer
	logic [15:0] acc_addr_r;
	logic [15:0] acc_addr_nxt;
	logic        acc_we_r;
	logic [7:0]  acc_wdata_r;
	logic [1:0]  cnt_r;
	logic [1:0]  extra_cycles;
	logic        addr_is_ext;

	assign addr_is_ext  = cpu_addr >= (SMALL_VARIANT ? XMC_INT_TOP_SMALL : XMC_INT_TOP_LARGE);
	assign extra_cycles = (wait_r == XMC_WS_NONE) ? XMC_WS_NONE :
		(wait_r == XMC_WS_ONE) ? XMC_WS_ONE : XMC_WS_TWO;
	assign acc_addr_nxt = (state_r == XMC_ST_IDLE && cpu_req) ? cpu_addr : acc_addr_r;

	// next state; external strobes only follow an external address
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			XMC_ST_IDLE:
				if (cpu_req)
					state_nxt = ext_mem_enable ? XMC_ST_ADDR : XMC_ST_DONE;
			XMC_ST_ADDR:
				state_nxt = XMC_ST_LATCH;
			XMC_ST_LATCH:
				state_nxt = acc_ext_r ? XMC_ST_STROBE : XMC_ST_DONE;
			XMC_ST_STROBE:
				if (cnt_r == 2'h0)
				begin
					if (!acc_we_r)
						state_nxt = XMC_ST_SYNC;
					else
						state_nxt = (wait_r == XMC_WS_HOLD) ? XMC_ST_HOLD : XMC_ST_DONE;
				end
			XMC_ST_SYNC:
				if (cnt_r == 2'h0)
					state_nxt = (wait_r == XMC_WS_HOLD) ? XMC_ST_HOLD : XMC_ST_DONE;
			XMC_ST_HOLD:
				state_nxt = XMC_ST_DONE;
			XMC_ST_DONE:
				state_nxt = XMC_ST_IDLE;
			default:
				state_nxt = XMC_ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			state_r <= XMC_ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// capture of the request; the sector is judged before the access starts
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			acc_addr_r  <= 16'h0000;
			acc_we_r    <= 1'b0;
			acc_wdata_r <= 8'h00;
			acc_ext_r   <= 1'b0;
			wait_r      <= XMC_WS_NONE;
		end
		else if (state_r == XMC_ST_IDLE && cpu_req)
		begin
			acc_addr_r  <= acc_addr_nxt;
			acc_we_r    <= cpu_we;
			acc_wdata_r <= cpu_wdata;
			acc_ext_r   <= addr_is_ext && ext_mem_enable;
			wait_r      <= dec_bus.wait_code;
		end
	end

	// strobe stretch and synchroniser lag counter
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			cnt_r <= 2'h0;
		else if (state_r == XMC_ST_LATCH)
			cnt_r <= extra_cycles;
		else if (state_r == XMC_ST_STROBE && cnt_r == 2'h0)
			cnt_r <= XMC_SYNC_LAG;
		else if (cnt_r != 2'h0)
			cnt_r <= cnt_r - 2'h1;
	end

	// answer to the cpu; read data are taken as the synchroniser lag count runs out in the sync state
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cpu_ack   <= 1'b0;
			cpu_rdata <= 8'h00;
			cpu_ext   <= 1'b0;
		end
		else
		begin
			cpu_ack <= (state_nxt == XMC_ST_DONE);
			// a disabled access reaches done in the same cycle as its capture, so a stale external flag must not leak
			cpu_ext <= (state_nxt == XMC_ST_DONE) ? (acc_ext_r && state_r != XMC_ST_IDLE) :
				cpu_ext;
			if (state_r == XMC_ST_SYNC && cnt_r == 2'h0)
				cpu_rdata <= ad_sync;
			else if (state_r == XMC_ST_IDLE && cpu_req)
				cpu_rdata <= 8'h00;
		end
	end

	// ==========================================================
	// pin takeover, registered from the next state so pins line up with state_r
	logic [7:0] ha_sel;
	logic       nxt_addr_ph;
	logic       nxt_strobe;

	assign ha_sel = (high_addr_mask == XMC_MASK_ALL) ? XMC_HA_NONE :
		(XMC_HA_FULL >> high_addr_mask);
	assign nxt_addr_ph = (state_nxt == XMC_ST_ADDR) || (state_nxt == XMC_ST_LATCH);
	assign nxt_strobe  = (state_nxt == XMC_ST_STROBE) || (state_nxt == XMC_ST_SYNC);

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			muxed_addr_data_out  <= 8'h00;
			muxed_addr_data_oe_n <= 1'b1;
			high_addr_bus_out    <= 8'h00;
			high_addr_bus_oe_n   <= 8'hFF;
			ale_out              <= 1'b0;
			ale_oe_n             <= 1'b1;
			rd_n_out             <= 1'b1;
			rd_oe_n              <= 1'b1;
			wr_n_out             <= 1'b1;
			wr_oe_n              <= 1'b1;
		end
		else if (ext_mem_enable)
		begin
			// address phase drives the low byte, writes then drive data
			if (nxt_addr_ph)
				muxed_addr_data_out <= acc_addr_nxt[7:0];
			else
				muxed_addr_data_out <= acc_wdata_r;
			muxed_addr_data_oe_n <= !(nxt_addr_ph || (acc_we_r && acc_ext_r &&
				(state_nxt == XMC_ST_STROBE || state_nxt == XMC_ST_HOLD)));
			high_addr_bus_out <= (acc_addr_nxt[15:8] & ha_sel) | (ha_port_val & ~ha_sel);
			high_addr_bus_oe_n <= ~(ha_sel | ha_port_dir);
			ale_out  <= (state_nxt == XMC_ST_ADDR);
			ale_oe_n <= 1'b0;
			rd_n_out <= !(nxt_strobe && !acc_we_r && acc_ext_r);
			rd_oe_n  <= 1'b0;
			wr_n_out <= !((state_nxt == XMC_ST_STROBE) && acc_we_r && acc_ext_r);
			wr_oe_n  <= 1'b0;
		end
		else
		begin
			// ordinary port value and direction control
			muxed_addr_data_out  <= ad_port_val;
			muxed_addr_data_oe_n <= !(&ad_port_dir);
			high_addr_bus_out    <= ha_port_val;
			high_addr_bus_oe_n   <= ~ha_port_dir;
			ale_out              <= ctl_port_val[0];
			ale_oe_n             <= !ctl_port_dir[0];
			rd_n_out             <= ctl_port_val[1];
			rd_oe_n              <= !ctl_port_dir[1];
			wr_n_out             <= ctl_port_val[2];
			wr_oe_n              <= !ctl_port_dir[2];
		end
	end

	// ==========================================================
	// bus keeper; not gated by the enable bit so it also guards a released bus
	assign keeper_en = bus_keeper_enable;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			keeper_val <= 8'h00;
		else if (!muxed_addr_data_oe_n)
			keeper_val <= muxed_addr_data_out;
	end

	// ==========================================================
	// checks
	sequence seq_wr_two;
		!wr_n_out ##1 !wr_n_out ##1 wr_n_out;
	endsequence

	sequence seq_wr_three;
		!wr_n_out ##1 !wr_n_out ##1 !wr_n_out ##1 wr_n_out;
	endsequence

	sequence seq_latch_held;
		!ale_out ##1 !ale_out;
	endsequence

	AST_EN_TAKEOVER: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(ext_mem_enable) |=> !ale_oe_n && !rd_oe_n && !wr_oe_n)
		else $error("bus strobes not taken over after enable");

	AST_DIS_RETURN: assert property (@(posedge core_clk) disable iff (!nrst)
		$fell(ext_mem_enable) |=> high_addr_bus_oe_n == ~$past(ha_port_dir))
		else $error("high pins not returned to port control");

	AST_SINGLE_SECTOR: assert property (@(posedge core_clk) disable iff (!nrst)
		dec_bus.sector_limit_sel < 3'h2 |-> dec_bus.in_upper &&
		dec_bus.wait_code == dec_bus.upper_wait)
		else $error("low limit code did not give one upper sector");

	AST_UPPER_START: assert property (@(posedge core_clk) disable iff (!nrst)
		dec_bus.sector_limit_sel >= 3'h2 |->
		(dec_bus.in_upper == (cpu_addr >= {dec_bus.sector_limit_sel, 13'h0000})))
		else $error("upper sector start mismatch");

	AST_WAIT_ONE: assert property (@(posedge core_clk) disable iff (!nrst)
		$fell(wr_n_out) && wait_r == 2'h1 |-> seq_wr_two)
		else $error("one-wait write strobe length wrong");

	AST_WAIT_TWO: assert property (@(posedge core_clk) disable iff (!nrst)
		$fell(wr_n_out) && wait_r == 2'h2 |-> seq_wr_three)
		else $error("two-wait write strobe length wrong");

	AST_HOLD_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(wr_n_out) && wait_r == 2'h3 |-> !ale_out ##1 (!ale_out && cpu_ack))
		else $error("no hold-off cycle before next address");

	AST_KEEPER_LAST: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(muxed_addr_data_oe_n) |=> keeper_val == $past(muxed_addr_data_out, 2))
		else $error("keeper lost the last driven value");

	AST_RES_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
		s_axi_rvalid && rd_sel_b_r |-> s_axi_rdata[6:3] == 4'h0)
		else $error("reserved bits read non-zero");

	AST_HA_FULL: assert property (@(posedge core_clk) disable iff (!nrst)
		ext_mem_enable && high_addr_mask == 3'h0 && state_r == XMC_ST_ADDR |->
		high_addr_bus_oe_n == 8'h00 && high_addr_bus_out == acc_addr_r[15:8])
		else $error("high address byte not driven in full");

	AST_INT_NO_STROBE: assert property (@(posedge core_clk) disable iff (!nrst)
		state_r != XMC_ST_IDLE && !acc_ext_r |-> rd_n_out && wr_n_out)
		else $error("strobe on an internal access");

	AST_ALE_ADDR: assert property (@(posedge core_clk) disable iff (!nrst)
		$fell(ale_out) && acc_ext_r |-> muxed_addr_data_out == acc_addr_r[7:0] &&
		!muxed_addr_data_oe_n ##1 seq_latch_held)
		else $error("low address not valid at latch fall");
endmodule
`default_nettype wire

// ===== src/xmc_pkg.sv
// constants and types for the external memory bus controller
// assumes a single core clock domain and an axi4-lite register port
package xmc_pkg;

	// ==========================================================
	// register map (byte addresses on the register port)
	localparam logic [7:0] XMC_OFF_SECT_WAIT = 8'h00;
	localparam logic [7:0] XMC_OFF_KEEP_MASK = 8'h04;
	localparam logic [7:0] XMC_OFF_STATUS    = 8'h08;
	localparam logic [7:0] XMC_RST_SECT_WAIT = 8'h00;
	localparam logic [7:0] XMC_RST_KEEP_MASK = 8'h00;

	// ==========================================================
	// field positions
	localparam int XMC_EN_BIT      = 7;
	localparam int XMC_LIM_LSB     = 4;
	localparam int XMC_UPW_LSB     = 2;
	localparam int XMC_LOW_LSB     = 0;
	localparam int XMC_KEEP_BIT    = 7;
	localparam int XMC_MASK_LSB    = 0;
	localparam logic [7:0] XMC_KEEP_RD_MASK = 8'h87; // reserved bits read zero

	// ==========================================================
	// address space
	localparam logic [15:0] XMC_INT_TOP_LARGE = 16'h2100;
	localparam logic [15:0] XMC_INT_TOP_SMALL = 16'h1100;
	localparam int          XMC_SECT_LSB      = 13; // sector starts on 8 KB steps
	localparam logic [2:0]  XMC_LIM_FIRST     = 3'h2;
	localparam logic [2:0]  XMC_MASK_ALL      = 3'h7;
	localparam logic [7:0]  XMC_HA_FULL       = 8'hFF;
	localparam logic [7:0]  XMC_HA_NONE       = 8'h00;

	// ==========================================================
	// wait-state codes and timing counts
	localparam logic [1:0] XMC_WS_NONE = 2'h0;
	localparam logic [1:0] XMC_WS_ONE  = 2'h1;
	localparam logic [1:0] XMC_WS_TWO  = 2'h2;
	localparam logic [1:0] XMC_WS_HOLD = 2'h3;
	localparam logic [1:0] XMC_SYNC_LAG = 2'h3; // three flops plus the agreement stage must settle

	localparam logic [1:0] XMC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] XMC_RESP_DECERR = 2'h3;

	typedef enum {
		XMC_ST_IDLE,
		XMC_ST_ADDR,
		XMC_ST_LATCH,
		XMC_ST_STROBE,
		XMC_ST_SYNC,
		XMC_ST_HOLD,
		XMC_ST_DONE
	} xmc_state_t;

endpackage

// ===== src/xmc_dec_if.sv
// carrier between the bus sequencer and the sector decoder
// assumes both ends sit in the core clock domain
`timescale 1ns/1ps
`default_nettype none
interface xmc_dec_if;
	logic [15:0] addr;
	logic [2:0]  sector_limit_sel;
	logic [1:0]  upper_wait;
	logic [1:0]  lower_wait;
	logic [1:0]  wait_code;
	logic        in_upper;

	modport dec (input addr, input sector_limit_sel, input upper_wait, input lower_wait,
		output wait_code, output in_upper);
	modport ctl (output addr, output sector_limit_sel, output upper_wait, output lower_wait,
		input wait_code, input in_upper);
endinterface
`default_nettype wire

// ===== src/xmc_sync3.sv
// three-flop input synchroniser with agreement filter
// assumes the input is asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module xmc_sync3 #(
	parameter int W = 8
) (
	input  wire logic         core_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// ==========================================================
	// chain; first stage feeds only the second
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a new value counts only once two later stages agree
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			dout <= '0;
		else if (s2_r == s3_r)
			dout <= s3_r;
	end
endmodule
`default_nettype wire

// ===== src/xmc_sector_dec.sv
// sector decoder: picks the wait-state code for an access address
// assumes the address is stable in the cycle it is sampled
`timescale 1ns/1ps
`default_nettype none
module xmc_sector_dec
	import xmc_pkg::*;
(
	xmc_dec_if.dec d
);
	// ==========================================================
	// codes below the first limit give one upper sector only
	always_comb
	begin
		if (d.sector_limit_sel < XMC_LIM_FIRST)
			d.in_upper = 1'b1;
		else
			d.in_upper = (d.addr[15:XMC_SECT_LSB] >= d.sector_limit_sel);
		d.wait_code = d.in_upper ? d.upper_wait : d.lower_wait;
	end
endmodule
`default_nettype wire

// ===== dv/xmc_sram_model.sv
// external sram seen through an address latch, plus the wire on the low bus
// assumes registered design pins that change only after core_clk rises
`timescale 1ns/1ps
`default_nettype none
module xmc_sram_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] muxed_addr_data_out,
	input  wire logic       muxed_addr_data_oe_n,
	input  wire logic [7:0] high_addr_bus_out,
	input  wire logic       ale_out,
	input  wire logic       rd_n_out,
	input  wire logic       wr_n_out,
	input  wire logic       keeper_en,
	input  wire logic [7:0] keeper_val,
	output var  logic [7:0] muxed_addr_data_in
);
	logic [7:0]  mem [65536];
	logic [7:0]  lo_r   = 8'h00;
	logic [7:0]  last_r = 8'h00;
	wire  [15:0] addr   = {high_addr_bus_out, lo_r};
	// ==========================================================
	// latch is transparent while the strobe is high and holds once it falls
	always @(posedge core_clk) if (ale_out) lo_r <= muxed_addr_data_in;
	// write data taken while the write strobe is low
	always @(posedge core_clk) if (!wr_n_out) mem[addr] <= muxed_addr_data_in;
	always @(posedge core_clk) last_r <= muxed_addr_data_in;
	// a floating bus shows the inverse, so a stale value never passes as kept
	always_comb
	begin
		if (!muxed_addr_data_oe_n)
			muxed_addr_data_in = muxed_addr_data_out;
		else if (!rd_n_out)
			muxed_addr_data_in = mem[addr];
		else if (keeper_en)
			muxed_addr_data_in = keeper_val;
		else
			muxed_addr_data_in = ~last_r;
	end
endmodule
`default_nettype wire

// ===== dv/test_ext_memory_bus_control.sv
// self-checking bench: register port tasks, cpu access task, pin checks
// assumes the sram model drives the low bus input
`timescale 1ns/1ps
`default_nettype none
module test_ext_memory_bus_control;
	import xmc_pkg::*;
	logic        core_clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, cpu_req = 0, cpu_we = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, cpu_wdata = 0, ad_port_val = 8'h5A;
	logic [7:0]  ad_port_dir = 8'hFF, ha_port_val = 8'hC3, ha_port_dir = 8'h0F;
	logic [2:0]  ctl_port_val = 3'h7, ctl_port_dir = 3'h0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic [15:0] cpu_addr = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_ack;
	logic        cpu_ext, muxed_addr_data_oe_n, ale_out, ale_oe_n, rd_n_out, rd_oe_n, wr_n_out;
	logic        wr_oe_n, keeper_en;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0]  cpu_rdata, muxed_addr_data_in, muxed_addr_data_out, high_addr_bus_out, rel;
	logic [7:0]  high_addr_bus_oe_n, keeper_val;
	int          failures = 0, samples_checked = 0;

	xmc_top u_xmc_top (.*);
	xmc_sram_model u_xmc_sram_model (.*);

	// ==========================================================
	// clock, watchdog and verdict
	always #12.5 core_clk = ~core_clk;
	// the whole sequence needs well under 2000 cycles
	initial
	begin
		#100000;
		failures++;
		tally_and_finish;
	end
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// ==========================================================
	// register port: payloads held until their own ready edge
	task regw(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0000, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
		chk("bresp", XMC_RESP_OKAY, s_axi_bresp);
	endtask
	task regr(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask

	// ==========================================================
	// cpu access: edges from request to the edge that sees the ack
	function automatic int lat(input logic we, en, ext, input logic [1:0] c);
		if (!en) return 2;
		if (!ext) return 4;
		return 5 + (c == 0 ? 0 : c == 1 ? 1 : 2) + (c == 3) + (we ? 0 : 4);
	endfunction
	task cpu(input logic we, input logic [15:0] a, input logic [7:0] d,
		input logic en, ext, input logic [1:0] c);
		int   k;
		logic s;
		k = 0;
		s = 0;
		@(posedge core_clk);
		cpu_req <= 1;
		cpu_we <= we;
		cpu_addr <= a;
		cpu_wdata <= d;
		do
		begin
			@(posedge core_clk);
			k++;
			if (!rd_n_out || !wr_n_out) s = 1;
		end while (cpu_ack !== 1'b1 && k < 40);
		cpu_req <= 0;
		chk("cycles", lat(we, en, ext, c), k);
		chk("strobe", en && ext, s);
		chk("ext flag", en && ext, cpu_ext);
		if (!we) chk("cpu rdata", (en && ext) ? d : 8'h00, cpu_rdata);
		if (we && en && ext) chk("keeper", d, keeper_val);
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		repeat (6) @(posedge core_clk);
		nrst <= 1;
		regr(XMC_OFF_SECT_WAIT);
		chk("sect reset", XMC_RST_SECT_WAIT, rd);
		regr(XMC_OFF_KEEP_MASK);
		chk("keep reset", XMC_RST_KEEP_MASK, rd);
		regr(8'h0C);
		chk("unmapped resp", XMC_RESP_DECERR, rsp);
		chk("ha oe", 8'(~ha_port_dir), high_addr_bus_oe_n);
		chk("ha out", ha_port_val, high_addr_bus_out);
		chk("wr oe", 1, wr_oe_n);
		cpu(1, 16'h8001, 8'h11, 0, 1, 0);
		regw(XMC_OFF_KEEP_MASK, 8'hFF);
		regr(XMC_OFF_KEEP_MASK);
		chk("reserved", 8'h87, rd);
		chk("keeper en", 1, keeper_en);
		for (int c = 0; c < 4; c++)
		begin
			regw(XMC_OFF_SECT_WAIT, 8'h80 | (c << 2));
			regw(XMC_OFF_KEEP_MASK, 8'h80);
			chk("wr oe", 0, wr_oe_n);
			chk("rd oe", 0, rd_oe_n);
			cpu(1, 16'h8000 + c, 8'hA0 + c, 1, 1, c);
			cpu(0, 16'h8000 + c, 8'hA0 + c, 1, 1, c);
		end
		regw(XMC_OFF_SECT_WAIT, 8'hA2);
		cpu(1, 16'h3FFF, 8'h3C, 1, 1, 2);
		cpu(1, 16'h4000, 8'h40, 1, 1, 0);
		cpu(0, 16'h3FFF, 8'h3C, 1, 1, 2);
		regr(XMC_OFF_STATUS);
		chk("status", 32'h0000_0006, rd);
		cpu(1, 16'h20FF, 8'h77, 1, 0, 0);
		cpu(0, 16'h0100, 8'h00, 1, 0, 0);
		for (int m = 0; m < 8; m++)
		begin
			regw(XMC_OFF_KEEP_MASK, m);
			// pins follow the register one edge later
			@(negedge core_clk);
			rel = (m == 7) ? 8'hFF : ~(8'hFF >> m);
			chk("ha mask oe", ~ha_port_dir & rel, high_addr_bus_oe_n);
			chk("keeper off", 0, keeper_en);
		end
		// released top pins driven low by the port reach the bottom of memory
		ha_port_val <= 8'h00;
		ha_port_dir <= 8'hFF;
		regw(XMC_OFF_KEEP_MASK, 8'h02);
		cpu(1, 16'h4001, 8'hAA, 1, 1, 0);
		regw(XMC_OFF_KEEP_MASK, 8'h00);
		cpu(1, 16'h4001, 8'h55, 1, 1, 0);
		regw(XMC_OFF_KEEP_MASK, 8'h02);
		cpu(0, 16'h4001, 8'hAA, 1, 1, 0);
		// full mask first, so enabled and disabled pin enables differ
		ha_port_dir <= 8'h0F;
		regw(XMC_OFF_KEEP_MASK, 8'h00);
		regw(XMC_OFF_SECT_WAIT, 8'h00);
		@(negedge core_clk);
		chk("ha oe", 8'(~ha_port_dir), high_addr_bus_oe_n);
		tally_and_finish;
	end
endmodule
`default_nettype wire
